// ### can_tx_dev.sv
// Transmit buffer manager: three buffers, priority pick, abort, one-shot.
// Assumes a protocol engine that starts on a pulse and reports one result.
`timescale 1ns/10ps

module can_tx_dev
    import can_tx_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Host link
    can_tx_link.dev         link,
    // Protocol engine
    input  wire logic       eng_bus_idle,
    output logic            eng_start,
    output logic [1:0]      eng_buf,
    input  wire logic       eng_done,
    input  wire logic       eng_lost,
    input  wire logic       eng_err,
    input  wire logic [3:0] eng_rd_idx,
    output logic [7:0]      eng_rd_data
);
    typedef enum logic {ST_IDLE, ST_ACTIVE} state_type;

    ////////////////////////////////////////////////////////////////////////
    // Decoders

    // Buffer window hit: {hit, index, offset}
    function automatic logic [6:0] buf_decode(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - BUF_BASE;
        buf_decode = {(a >= BUF_BASE) && (rel[7:4] < NUM_BUF) && (rel[3:0] < BUF_BYTES), rel[5:4], rel[3:0]};
    endfunction

    // Pending pick: {found, index}
    function automatic logic [2:0] pick(input logic [2:0] pend, input logic [5:0] pr);
        logic       found;
        logic [1:0] best;
        logic [1:0] bp;
        found = 1'b0;
        best  = 2'd0;
        bp    = 2'd0;
        // Ascending scan with >= lets the larger index win ties
        for (int i = 0; i < NUM_BUF; i++) begin
            if (pend[i] && (!found || pr[2*i +: 2] >= bp)) begin
                found = 1'b1;
                best  = 2'(i);
                bp    = pr[2*i +: 2];
            end
        end
        pick = {found, best};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    state_type  state_r, state_nxt;
    logic [1:0] cur_r, cur_nxt;
    logic       start_r, start_nxt;
    logic       abort_seen_r, abort_seen_nxt;
    logic [2:0] req_r, req_nxt;
    logic [5:0] prio_r, prio_nxt;
    logic [2:0] aborted_flag_r, aborted_flag_nxt;
    logic [2:0] lost_arbitration_flag_r, lost_arbitration_flag_nxt;
    logic [2:0] terr_r, terr_nxt;
    logic [2:0] done_r, done_nxt;
    logic       merr_r, merr_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] int_en_r, int_en_nxt;
    logic [2:0] pin_mode_r, pin_mode_nxt;
    logic [2:0] pin_prev_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] eng_data_r, eng_data_nxt;
    logic [7:0] mem_r [NUM_BUF][BODY_BYTES];
    logic [7:0] mem_nxt [NUM_BUF][BODY_BYTES];

    logic [6:0] dec;
    logic [2:0] set_req;
    logic [2:0] sel;
    logic       fail;
    logic       drop;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        state_nxt      = state_r;
        cur_nxt        = cur_r;
        start_nxt      = 1'b0;
        abort_seen_nxt = abort_seen_r;
        req_nxt        = req_r;
        prio_nxt       = prio_r;
        aborted_flag_nxt       = aborted_flag_r;
        lost_arbitration_flag_nxt       = lost_arbitration_flag_r;
        terr_nxt       = terr_r;
        done_nxt       = done_r;
        merr_nxt       = merr_r;
        ctrl_nxt       = ctrl_r;
        int_en_nxt     = int_en_r;
        pin_mode_nxt   = pin_mode_r;
        mem_nxt        = mem_r;
        rdata_nxt      = 8'h00;
        set_req        = 3'b000;
        dec            = buf_decode(link.addr);
        sel            = pick(req_r, prio_r);
        fail           = eng_lost | eng_err;
        drop           = 1'b0;

        // Host writes; flag clears come first so hardware sets win
        if (link.wr) begin
            if (dec[6]) begin
                if (dec[3:0] == 4'(CTRL_OFF)) begin
                    req_nxt[dec[5:4]]          = link.wdata[REQ_BIT];
                    prio_nxt[2*dec[5:4] +: 2]  = link.wdata[PRIO_LSB +: 2];
                    set_req[dec[5:4]]          = link.wdata[REQ_BIT] & ~req_r[dec[5:4]];
                end else begin
                    mem_nxt[dec[5:4]][dec[3:0] - 4'd1] = link.wdata;
                end
            end
            case (link.addr)
                CTRL_ADDR:     ctrl_nxt   = link.wdata & CTRL_MASK;
                INT_EN_ADDR:   int_en_nxt = link.wdata;
                INT_FLAG_ADDR: begin
                    done_nxt = link.wdata[2:0];
                    merr_nxt = link.wdata[MERR_BIT];
                end
                RTS_CMD_ADDR:  set_req = set_req | (link.wdata[2:0] & ~req_r);
                PIN_CTRL_ADDR: begin
                    if (ctrl_r[CONFIG_BIT]) begin
                        pin_mode_nxt = link.wdata[2:0];
                    end
                end
                default: ;
            endcase
        end

        // Falling edge on a pin in request mode
        set_req = set_req | (pin_mode_r & pin_prev_r & ~link.rts_n & ~req_r);
        req_nxt = req_nxt | set_req;
        aborted_flag_nxt = aborted_flag_nxt & ~set_req;
        lost_arbitration_flag_nxt = lost_arbitration_flag_nxt & ~set_req;
        terr_nxt = terr_nxt & ~set_req;

        // Abort-all drops every queued buffer not on the bus
        if (ctrl_r[ABORT_BIT]) begin
            for (int i = 0; i < NUM_BUF; i++) begin
                if (req_r[i] && !(state_r == ST_ACTIVE && cur_r == 2'(i))) begin
                    req_nxt[i]  = 1'b0;
                    aborted_flag_nxt[i] = 1'b1;
                end
            end
        end

        case (state_r)
            ST_IDLE: begin
                // Nothing leaves while abort-all stands
                if (eng_bus_idle && sel[2] && !ctrl_r[ABORT_BIT]) begin
                    start_nxt      = 1'b1;
                    cur_nxt        = sel[1:0];
                    abort_seen_nxt = 1'b0;
                    state_nxt      = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (ctrl_r[ABORT_BIT]) begin
                    abort_seen_nxt = 1'b1;
                end
                if (eng_done) begin
                    req_nxt[cur_r]  = 1'b0;
                    done_nxt[cur_r] = 1'b1;
                    state_nxt       = ST_IDLE;
                end else if (fail) begin
                    lost_arbitration_flag_nxt[cur_r] = lost_arbitration_flag_nxt[cur_r] | eng_lost;
                    terr_nxt[cur_r] = terr_nxt[cur_r] | eng_err;
                    merr_nxt        = merr_nxt | eng_err;
                    drop            = ctrl_r[SINGLE_BIT] | ctrl_r[ABORT_BIT] | abort_seen_r;
                    // Request stays for a retry unless single attempt or abort
                    if (drop) begin
                        req_nxt[cur_r] = 1'b0;
                    end
                    if ((ctrl_r[ABORT_BIT] | abort_seen_r) && req_r[cur_r]) begin
                        aborted_flag_nxt[cur_r] = 1'b1;
                    end
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase

        // Read data, valid the cycle after the strobe
        if (link.rd) begin
            if (dec[6]) begin
                if (dec[3:0] == 4'(CTRL_OFF)) begin
                    rdata_nxt[ABORTED_FLAG_BIT]       = aborted_flag_r[dec[5:4]];
                    rdata_nxt[LOST_ARBITRATION_FLAG_BIT]       = lost_arbitration_flag_r[dec[5:4]];
                    rdata_nxt[TERR_BIT]       = terr_r[dec[5:4]];
                    rdata_nxt[REQ_BIT]        = req_r[dec[5:4]];
                    rdata_nxt[PRIO_LSB +: 2]  = prio_r[2*dec[5:4] +: 2];
                end else begin
                    rdata_nxt = mem_r[dec[5:4]][dec[3:0] - 4'd1];
                end
            end
            case (link.addr)
                CTRL_ADDR:     rdata_nxt = ctrl_r;
                INT_EN_ADDR:   rdata_nxt = int_en_r;
                INT_FLAG_ADDR: begin
                    rdata_nxt[2:0]      = done_r;
                    rdata_nxt[MERR_BIT] = merr_r;
                end
                PIN_CTRL_ADDR: begin
                    rdata_nxt[2:0]                = pin_mode_r;
                    rdata_nxt[PIN_STATE_LSB +: 3] = link.rts_n & ~pin_mode_r;
                end
                default: ;
            endcase
        end

        // Engine fetch of the active buffer's body
        eng_data_nxt = (eng_rd_idx < 4'(BODY_BYTES)) ? mem_r[cur_r][eng_rd_idx] : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r      <= ST_IDLE;
            cur_r        <= 2'd0;
            start_r      <= 1'b0;
            abort_seen_r <= 1'b0;
            req_r        <= 3'b000;
            prio_r       <= 6'h00;
            aborted_flag_r       <= 3'b000;
            lost_arbitration_flag_r       <= 3'b000;
            terr_r       <= 3'b000;
            done_r       <= 3'b000;
            merr_r       <= 1'b0;
            ctrl_r       <= CTRL_RESET;
            int_en_r     <= 8'h00;
            pin_mode_r   <= 3'b000;
            pin_prev_r   <= 3'b111;     // Pins idle high, no edge at release
            rdata_r      <= 8'h00;
            eng_data_r   <= 8'h00;
            for (int b = 0; b < NUM_BUF; b++) begin
                for (int k = 0; k < BODY_BYTES; k++) begin
                    mem_r[b][k] <= 8'h00;
                end
            end
        end else begin
            state_r      <= state_nxt;
            cur_r        <= cur_nxt;
            start_r      <= start_nxt;
            abort_seen_r <= abort_seen_nxt;
            req_r        <= req_nxt;
            prio_r       <= prio_nxt;
            aborted_flag_r       <= aborted_flag_nxt;
            lost_arbitration_flag_r       <= lost_arbitration_flag_nxt;
            terr_r       <= terr_nxt;
            done_r       <= done_nxt;
            merr_r       <= merr_nxt;
            ctrl_r       <= ctrl_nxt;
            int_en_r     <= int_en_nxt;
            pin_mode_r   <= pin_mode_nxt;
            pin_prev_r   <= link.rts_n;
            rdata_r      <= rdata_nxt;
            eng_data_r   <= eng_data_nxt;
            mem_r        <= mem_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign eng_start    = start_r;
    assign eng_buf      = cur_r;
    assign eng_rd_data  = eng_data_r;
    assign link.rdata   = rdata_r;
    assign link.pending = req_r;
    // Interrupt pin, low while any enabled flag stands
    assign link.irq_n   = ~(|(done_r & int_en_r[2:0]) | (merr_r & int_en_r[MERR_BIT]));
endmodule

// ### can_tx_host.sv
// Host end: forwards software accesses to the buffer manager and guards them.
// Assumes software follows the one-cycle strobe port; reads return next cycle.
`timescale 1ns/10ps
module can_tx_host
    import can_tx_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Software command port
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    output logic [7:0]      cmd_rdata,
    // Request pin drive and interrupt
    input  wire logic [2:0] req_pin_n,
    output logic            irq_out_n,
    // Device link
    can_tx_link.host        link
);
    logic [8:0] loaded_r, loaded_nxt;      // {dlc, sidl, sidh} per buffer
    logic       en_init_r, en_init_nxt;
    logic       refused_r, refused_nxt;
    logic       abort_r, abort_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic       stat_rd_r, stat_rd_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic [2:0] pins_r;
    logic       refuse;
    logic       auto_wr;
    logic [7:0] rel;
    logic [1:0] bi;
    logic       in_buf;
    logic [2:0] ready;

    ////////////////////////////////////////////////////////////////////////
    // Guard and shadow logic

    always_comb begin
        loaded_nxt  = loaded_r;
        en_init_nxt = en_init_r;
        refused_nxt = refused_r;
        abort_nxt   = abort_r;
        ctrl_nxt    = ctrl_r;
        stat_rd_nxt = cmd_rd && (cmd_addr == HOST_STAT_ADDR);
        stat_nxt    = 8'h00;
        refuse      = 1'b0;
        rel         = cmd_addr - BUF_BASE;
        bi          = rel[5:4];
        in_buf      = (cmd_addr >= BUF_BASE) && (rel[7:4] < NUM_BUF) && (rel[3:0] < BUF_BYTES);
        for (int i = 0; i < NUM_BUF; i++) begin
            ready[i] = &loaded_r[3*i +: 3] & en_init_r & ~abort_r;
        end
        // Auto clear of abort-all once nothing is pending, in a free slot
        auto_wr = abort_r && (link.pending == 3'b000) && !cmd_wr && !cmd_rd;

        if (cmd_wr) begin
            if (in_buf && link.pending[bi]) begin
                refuse = rel[3:0] != 4'(CTRL_OFF) || cmd_wdata[REQ_BIT];
            end else if (in_buf && rel[3:0] == 4'(CTRL_OFF)) begin
                refuse = cmd_wdata[REQ_BIT] && !ready[bi];
            end else if (cmd_addr == RTS_CMD_ADDR) begin
                refuse = |(cmd_wdata[2:0] & ~ready);
            end
            if (in_buf && !refuse) begin
                case (int'(rel[3:0]) - 1)
                    SIDH_IDX: loaded_nxt[3*bi]     = 1'b1;
                    SIDL_IDX: loaded_nxt[3*bi + 1] = 1'b1;
                    DLC_IDX:  loaded_nxt[3*bi + 2] = 1'b1;
                    default: ;
                endcase
            end
            if (cmd_addr == INT_EN_ADDR) begin
                en_init_nxt = 1'b1;
            end
            if (cmd_addr == CTRL_ADDR) begin
                ctrl_nxt  = cmd_wdata & CTRL_MASK;
                abort_nxt = cmd_wdata[ABORT_BIT];
            end
            if (cmd_addr == HOST_STAT_ADDR) begin
                refused_nxt = 1'b0;
            end
            // Refusal wins over a clear in the same cycle
            refused_nxt = refused_nxt | refuse;
        end
        if (auto_wr) begin
            ctrl_nxt[ABORT_BIT] = 1'b0;
            abort_nxt           = 1'b0;
        end
        stat_nxt[HS_REFUSED_BIT]     = refused_r;
        stat_nxt[HS_ABORT_BIT]       = abort_r;
        stat_nxt[HS_PEND_LSB +: 3]   = link.pending;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk) begin
        if (reset) begin
            loaded_r  <= 9'h000;
            en_init_r <= 1'b0;
            refused_r <= 1'b0;
            abort_r   <= 1'b0;
            ctrl_r    <= CTRL_RESET;
            stat_rd_r <= 1'b0;
            stat_r    <= 8'h00;
            pins_r    <= 3'b111;
        end else begin
            loaded_r  <= loaded_nxt;
            en_init_r <= en_init_nxt;
            refused_r <= refused_nxt;
            abort_r   <= abort_nxt;
            ctrl_r    <= ctrl_nxt;
            stat_rd_r <= stat_rd_nxt;
            stat_r    <= stat_nxt;
            pins_r    <= req_pin_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link drive; strobes pass straight through so reads keep one-cycle latency

    assign link.wr    = (cmd_wr && !refuse && cmd_addr != HOST_STAT_ADDR) || auto_wr;
    assign link.rd    = cmd_rd && cmd_addr != HOST_STAT_ADDR;
    assign link.addr  = auto_wr ? CTRL_ADDR : cmd_addr;
    assign link.wdata = auto_wr ? ctrl_nxt : cmd_wdata;
    assign link.rts_n = pins_r;
    assign cmd_rdata  = stat_rd_r ? stat_r : link.rdata;
    assign irq_out_n  = link.irq_n;
endmodule

// ### can_tx_link.sv
// Link between host end and transmit buffer manager.
// Register port plus request pins, interrupt and pending bits.
`timescale 1ns/10ps
interface can_tx_link;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] rts_n;
    logic       irq_n;
    logic [2:0] pending;

    modport dev  (input addr, wdata, wr, rd, rts_n, output rdata, irq_n, pending);
    modport host (output addr, wdata, wr, rd, rts_n, input rdata, irq_n, pending);
endinterface

// ### can_tx_link_properties.sv
// Checker for the register link and request pins between both ends.
// Assumes only link signals are visible; pin mode is shadowed here.
`timescale 1ns/10ps
module can_tx_link_properties
    import can_tx_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Pins and status
    input wire logic [2:0] rts_n,
    input wire logic       irq_n,
    input wire logic [2:0] pending
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic       cfg_r;
    logic       cfg_nxt;
    // Shadow of pin mode; ignored writes outside configuration mode
    always_comb begin
        cfg_nxt  = cfg_r;
        mode_nxt = mode_r;
        if (wr && addr == CTRL_ADDR)
            cfg_nxt = wdata[CONFIG_BIT];
        if (wr && addr == PIN_CTRL_ADDR && cfg_r)
            mode_nxt = wdata[2:0];
    end
    always_ff @(posedge core_clk) begin
        cfg_r  <= reset ? 1'b1 : cfg_nxt;
        mode_r <= reset ? 3'b000 : mode_nxt;
    end
    ////////////////////////////////////////
    // Read data stands one cycle only
    AST_READ_ONE_CYCLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside answer cycle");
    AST_CTRL_READ: assert property ($past(rd) && $past(addr) == BUF_BASE |->
        !rdata[7] && !rdata[2] && rdata[REQ_BIT] == $past(pending[0]))
        else $error("control byte read wrong");
    AST_WRITE_SETS_REQ: assert property (wr && addr == BUF_BASE && wdata[REQ_BIT] |=> pending[0])
        else $error("control write did not set request");
    AST_CMD_SETS_REQ: assert property (wr && addr == RTS_CMD_ADDR |=>
        (pending & $past(wdata[2:0])) == $past(wdata[2:0]))
        else $error("request command ignored");
    AST_HOST_CLEAR: assert property (wr && addr == 8'h40 && !wdata[REQ_BIT] |=> !pending[1])
        else $error("host clear kept request");
    AST_PIN_SETS: assert property ($fell(rts_n[2]) && mode_r[2] && !pending[2] |=> pending[2])
        else $error("pin edge did not set request");
    AST_PIN_MODE_READ: assert property ($past(rd) && $past(addr) == PIN_CTRL_ADDR |->
        rdata[2:0] == $past(mode_r))
        else $error("pin mode changed outside configuration");
    AST_PEND_CAUSE: assert property ($rose(pending[0]) |->
        $past(wr) || (!$past(rts_n[0]) && $past(rts_n[0], 2)))
        else $error("request rose without cause");
    // Main scenarios reached
    cover property (wr && addr == RTS_CMD_ADDR);
    cover property ($fell(pending[1]));
    cover property ($fell(rts_n[2]) && mode_r[2]);
endmodule

// ### can_tx_pkg.sv
// Shared constants for the CAN transmit buffer manager and its host end.
// Assumes an 8-bit register port between host and device, one clock.
package can_tx_pkg;
    // Buffer geometry
    localparam int NUM_BUF    = 3;
    localparam int BUF_BYTES  = 14;
    localparam int ID_BYTES   = 5;
    localparam int DATA_BYTES = 8;
    localparam int BODY_BYTES = ID_BYTES + DATA_BYTES;
    localparam int CTRL_OFF   = 0;

    // Body byte offsets (body offset = buffer offset - 1)
    localparam int SIDH_IDX = 0;
    localparam int SIDL_IDX = 1;
    localparam int DLC_IDX  = 4;

    // Register map
    localparam logic [7:0] BUF_BASE       = 8'h30;
    localparam logic [7:0] PIN_CTRL_ADDR  = 8'h0D;
    localparam logic [7:0] CTRL_ADDR      = 8'h20;
    localparam logic [7:0] INT_EN_ADDR    = 8'h21;
    localparam logic [7:0] INT_FLAG_ADDR  = 8'h22;
    localparam logic [7:0] RTS_CMD_ADDR   = 8'h23;
    localparam logic [7:0] HOST_STAT_ADDR = 8'hFF;

    // Buffer control byte fields
    localparam int ABORTED_FLAG_BIT = 6;
    localparam int LOST_ARBITRATION_FLAG_BIT = 5;
    localparam int TERR_BIT = 4;
    localparam int REQ_BIT  = 3;
    localparam int PRIO_LSB = 0;

    // Controller control register fields
    localparam int         SINGLE_BIT = 0;
    localparam int         ABORT_BIT  = 1;
    localparam int         CONFIG_BIT = 2;
    localparam logic [7:0] CTRL_MASK  = 8'h07;
    localparam logic [7:0] CTRL_RESET = 8'h04;

    // Interrupt enable / flag fields (done flags at 2:0), and pin control state field
    localparam int MERR_BIT      = 5;
    localparam int PIN_STATE_LSB = 3;

    // Host status register fields
    localparam int HS_REFUSED_BIT = 0;
    localparam int HS_ABORT_BIT   = 1;
    localparam int HS_PEND_LSB    = 2;
endpackage

// ### test_can_transmit_buffer_manager.sv
// Testbench joining host end and buffer manager; bench acts as engine.
// Assumes one 100 MHz clock and synchronous active high reset.
`timescale 1ns/10ps
module test_can_transmit_buffer_manager
    import can_tx_pkg::*;
;
    logic       core_clk  = 1'b0;
    logic       reset     = 1'b1;
    logic [7:0] cmd_addr  = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic       cmd_wr    = 1'b0;
    logic       cmd_rd    = 1'b0;
    logic [7:0] cmd_rdata;
    logic [2:0] req_pin_n = 3'b111;
    logic       irq_out_n;
    logic       eng_bus_idle = 1'b0;
    logic       eng_start;
    logic [1:0] eng_buf;
    logic [1:0] last_buf;
    logic       eng_done = 1'b0;
    logic       eng_lost = 1'b0;
    logic       eng_err  = 1'b0;
    logic [3:0] eng_rd_idx = 4'h0;
    logic [7:0] eng_rd_data;
    int         err_count   = 0;
    int         comparisons = 0;
    int         starts      = 0;
    int         seen        = 0;
    ////////////////////////////////////////
    can_tx_link i_can_tx_link ();
    can_tx_host i_can_tx_host (.core_clk(core_clk), .reset(reset), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .req_pin_n(req_pin_n), .irq_out_n(irq_out_n), .link(i_can_tx_link));
    can_tx_dev i_can_tx_dev (.core_clk(core_clk), .reset(reset), .link(i_can_tx_link),
        .eng_bus_idle(eng_bus_idle), .eng_start(eng_start), .eng_buf(eng_buf), .eng_done(eng_done),
        .eng_lost(eng_lost), .eng_err(eng_err), .eng_rd_idx(eng_rd_idx), .eng_rd_data(eng_rd_data));
    can_tx_link_properties i_can_tx_link_properties (.core_clk(core_clk), .reset(reset),
        .addr(i_can_tx_link.addr), .wdata(i_can_tx_link.wdata), .wr(i_can_tx_link.wr),
        .rd(i_can_tx_link.rd), .rdata(i_can_tx_link.rdata), .rts_n(i_can_tx_link.rts_n),
        .irq_n(i_can_tx_link.irq_n), .pending(i_can_tx_link.pending));
    ////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    // Count frame starts so a start during a read is not missed
    always @(posedge core_clk) begin
        if (eng_start === 1'b1) begin
            starts   <= starts + 1;
            last_buf <= eng_buf;
        end
    end
    task automatic wrap_up;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cmd_wr    <= 1'b1;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask
    // Read data is looked at in the single cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        cmd_rd   <= 1'b1;
        cmd_addr <= a;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        #1;
        chk(cmd_rdata, exp);
    endtask
    // Bounded wait for the next start; buffer and first id byte checked
    task automatic wait_start(input logic [1:0] b);
        int n;
        n = 0;
        while (starts == seen && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (starts == seen) begin
            err_count++;
            $display("BAD %0t no frame start", $time);
            wrap_up();
        end else begin
            seen = starts;
            chk({6'h00, last_buf}, {6'h00, b});
            chk(eng_rd_data, 8'(16 + b));
        end
    endtask
    // Result pulse: bit0 done, bit1 lost, bit2 error
    task automatic give(input logic [2:0] r);
        @(posedge core_clk);
        {eng_err, eng_lost, eng_done} <= r;
        @(posedge core_clk);
        {eng_err, eng_lost, eng_done} <= 3'b000;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rd_chk(CTRL_ADDR, CTRL_RESET);
        rd_chk(BUF_BASE, 8'h00);
        rd_chk(8'h90, 8'h00);
        wr_reg(INT_EN_ADDR, 8'h27);
        for (int b = 0; b < 3; b++) begin
            wr_reg(8'(BUF_BASE + 16 * b + 1), 8'(16 + b));
            wr_reg(8'(BUF_BASE + 16 * b + 2), 8'h00);
            wr_reg(8'(BUF_BASE + 16 * b + 5), 8'h08);
        end
        rd_chk(8'h35, 8'h08);
        wr_reg(PIN_CTRL_ADDR, 8'h04);
        rd_chk(PIN_CTRL_ADDR, 8'h1C);
        wr_reg(CTRL_ADDR, 8'h00);
        wr_reg(PIN_CTRL_ADDR, 8'h07);
        rd_chk(PIN_CTRL_ADDR, 8'h1C);
        // Equal top priority on 0 and 1, lowest on 2
        wr_reg(BUF_BASE, 8'h0B);
        wr_reg(8'h40, 8'h0B);
        wr_reg(8'h50, 8'h08);
        rd_chk(BUF_BASE, 8'h0B);
        chk(8'(starts), 8'h00);
        // Engine inputs move on a rising edge only
        @(posedge core_clk);
        eng_bus_idle <= 1'b1;
        wait_start(1);
        give(3'b001);
        wait_start(0);
        give(3'b001);
        wait_start(2);
        give(3'b001);
        rd_chk(INT_FLAG_ADDR, 8'h07);
        rd_chk(8'h40, 8'h03);
        chk({7'h00, irq_out_n}, 8'h00);
        wr_reg(INT_FLAG_ADDR, 8'h00);
        rd_chk(INT_FLAG_ADDR, 8'h00);
        chk({7'h00, irq_out_n}, 8'h01);
        // Lost, then error, then success with retries between
        wr_reg(RTS_CMD_ADDR, 8'h01);
        wait_start(0);
        give(3'b010);
        rd_chk(BUF_BASE, 8'h2B);
        wait_start(0);
        give(3'b100);
        rd_chk(INT_FLAG_ADDR, 8'h20);
        wait_start(0);
        give(3'b001);
        // Single attempt
        wr_reg(CTRL_ADDR, 8'h01);
        wr_reg(RTS_CMD_ADDR, 8'h01);
        rd_chk(BUF_BASE, 8'h0B);
        wait_start(0);
        give(3'b010);
        rd_chk(BUF_BASE, 8'h23);
        chk(8'(starts - seen), 8'h00);
        // Refused body write, then host clear of a pending request
        @(posedge core_clk);
        eng_bus_idle <= 1'b0;
        wr_reg(RTS_CMD_ADDR, 8'h02);
        wr_reg(8'h41, 8'hAA);
        rd_chk(HOST_STAT_ADDR, 8'h09);
        wr_reg(HOST_STAT_ADDR, 8'h00);
        wr_reg(8'h40, 8'h03);
        rd_chk(8'h40, 8'h03);
        // Abort all while buffer 1 is on the bus
        wr_reg(RTS_CMD_ADDR, 8'h03);
        eng_bus_idle <= 1'b1;
        wait_start(1);
        wr_reg(CTRL_ADDR, 8'h02);
        rd_chk(BUF_BASE, 8'h43);
        rd_chk(8'h40, 8'h0B);
        give(3'b010);
        rd_chk(8'h40, 8'h63);
        repeat (4) @(posedge core_clk);
        rd_chk(CTRL_ADDR, 8'h00);
        // Request pin for buffer 2
        wr_reg(INT_FLAG_ADDR, 8'h00);
        req_pin_n <= 3'b011;
        wait_start(2);
        give(3'b001);
        // Engine fetch of the length byte of the buffer just sent
        eng_rd_idx <= 4'(DLC_IDX);
        rd_chk(INT_FLAG_ADDR, 8'h04);
        chk({7'h00, irq_out_n}, 8'h00);
        chk(eng_rd_data, 8'h08);
        wrap_up();
    end
endmodule
